// File: rtl/fcsp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 ce_i,
    input  wire logic [W-1:0]         in_data_i,
    input  wire logic                 in_valid_i,
    output logic                      in_ready_o,
    output logic [W-1:0]              out_data_o,
    output logic                      out_valid_o,
    input  wire logic                 out_ready_i,
    output logic [$clog2(D):0]        level_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [W-1:0]  mem_nxt [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   lvl_r, lvl_nxt;
    logic          push, pop;

    assign in_ready_o  = (lvl_r != (AW+1)'(D));
    assign out_valid_o = (lvl_r != '0);
    assign out_data_o  = mem_r[rp_r];
    assign level_o     = lvl_r;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        lvl_nxt = lvl_r;
        if (push) begin
            mem_nxt[wp_r] = in_data_i;
            wp_nxt        = wp_r + AW'(1);
        end
        if (pop) begin
            rp_nxt = rp_r + AW'(1);
        end
        if (push && !pop) begin
            lvl_nxt = lvl_r + (AW+1)'(1);
        end else if (pop && !push) begin
            lvl_nxt = lvl_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            lvl_r <= '0;
        end else if (ce_i) begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            lvl_r <= lvl_nxt;
        end
    end
endmodule : fcsp_fifo

module fcsp_tx (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] div_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  data_i,
    output logic             busy_o,
    output logic             txd_o
);
    fcsp_pkg::fcsp_ser_type st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic        txd_r, txd_nxt;
    logic        tick;

    assign tick   = (cnt_r == div_i - 16'h0001);
    assign busy_o = (st_r != fcsp_pkg::ST_IDLE);
    assign txd_o  = txd_r;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
        bit_nxt = bit_r;
        sh_nxt  = sh_r;
        txd_nxt = txd_r;
        unique case (st_r)
            fcsp_pkg::ST_IDLE: begin
                cnt_nxt = 16'h0000;
                if (start_i) begin
                    st_nxt  = fcsp_pkg::ST_START;
                    sh_nxt  = data_i;
                    txd_nxt = 1'b0;
                end
            end
            fcsp_pkg::ST_START: if (tick) begin
                st_nxt  = fcsp_pkg::ST_DATA;
                bit_nxt = 3'h0;
                txd_nxt = sh_r[0];
            end
            fcsp_pkg::ST_DATA: if (tick) begin
                sh_nxt = {1'b1, sh_r[7:1]};
                if (bit_r == 3'h7) begin
                    st_nxt  = fcsp_pkg::ST_STOP;
                    txd_nxt = 1'b1;
                end else begin
                    bit_nxt = bit_r + 3'h1;
                    txd_nxt = sh_r[1];
                end
            end
            fcsp_pkg::ST_STOP: if (tick) begin
                st_nxt = fcsp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r  <= fcsp_pkg::ST_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 3'h0;
            sh_r  <= 8'h00;
            txd_r <= 1'b1;
        end else if (ce_i) begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sh_r  <= sh_nxt;
            txd_r <= txd_nxt;
        end
    end
endmodule : fcsp_tx

module fcsp_ctrl (
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 ce_i,
    input  wire fcsp_pkg::fcsp_hs_type mode_i,
    input  wire logic [15:0]          div_i,
    input  wire logic [7:0]           tx_data_i,
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    output logic [7:0]                rx_data_o,
    output logic                      rx_valid_o,
    input  wire logic                 rx_ready_i,
    fcsp_if.ctrl                      lnk
);
    localparam int LW = $clog2(fcsp_pkg::FIFO_D) + 1;
    logic [2:0]    s1_r, s2_r;
    logic          busy, drive, honour, rx_vld;
    logic [7:0]    rx_data;
    logic [LW-1:0] lvl;
    logic [15:0]   div;

    assign div    = fcsp_pkg::fcsp_clamp_div(div_i);
    assign drive  = (mode_i == fcsp_pkg::HS_RTS) || (mode_i == fcsp_pkg::HS_RTSCTS);
    assign honour = (mode_i == fcsp_pkg::HS_CTS) || (mode_i == fcsp_pkg::HS_RTSCTS);
    assign lnk.send_permit_oe  = drive;
    // Leaving two slots free absorbs what the target may still send.
    assign lnk.send_permit_drv = lvl < LW'(fcsp_pkg::FIFO_D - fcsp_pkg::FIFO_SPARE);
    assign tx_ready_o = !busy && s2_r[2] && (!honour || s2_r[1]);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_r <= 3'h3;
            s2_r <= 3'h3;
        end else if (ce_i) begin
            s1_r <= {lnk.link_en, lnk.recv_permit, lnk.txd};
            s2_r <= s1_r;
        end
    end

    fcsp_tx u_tx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .div_i  (div),
        .start_i(tx_valid_i && tx_ready_o),
        .data_i (tx_data_i),
        .busy_o (busy),
        .txd_o  (lnk.rxd)
    );

    fcsp_rx u_rx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .div_i  (div),
        .rxd_i  (s2_r[2] ? s2_r[0] : 1'b1),
        .data_o (rx_data),
        .valid_o(rx_vld)
    );

    fcsp_fifo #(.W(fcsp_pkg::DATA_W), .D(fcsp_pkg::FIFO_D)) u_fifo (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .in_data_i  (rx_data),
        .in_valid_i (rx_vld),
        .in_ready_o (),
        .out_data_o (rx_data_o),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .level_o    (lvl)
    );
endmodule : fcsp_ctrl
`default_nettype wire

// File: rtl/fcsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcsp_if;
    logic txd;
    logic rxd;
    logic send_permit_drv;
    logic send_permit_oe;
    logic send_permit;
    logic recv_permit;
    logic link_en;

    // An undriven send-permit line is pulled to the permitting level.
    assign send_permit = send_permit_oe ? send_permit_drv : 1'b1;

    modport target (
        output txd,
        output recv_permit,
        output link_en,
        input  rxd,
        input  send_permit
    );
    modport ctrl (
        input  txd,
        input  recv_permit,
        input  link_en,
        output rxd,
        output send_permit_drv,
        output send_permit_oe
    );
endinterface : fcsp_if
`default_nettype wire

// File: rtl/fcsp_pkg.sv
package fcsp_pkg;
    localparam int          CLK_HZ     = 40_000_000;
    localparam int          BAUD_DEF   = 115_200;
    localparam int          BAUD_MIN   = 9_600;
    localparam int          BAUD_MAX   = 921_600;
    localparam logic [15:0] DIV_DEF    = 16'((CLK_HZ + BAUD_DEF / 2) / BAUD_DEF);
    localparam logic [15:0] DIV_MIN    = 16'(CLK_HZ / BAUD_MAX);
    localparam logic [15:0] DIV_MAX    = 16'(CLK_HZ / BAUD_MIN);
    localparam int          DATA_W     = 8;
    localparam int          FIFO_D     = 16;
    localparam int          FIFO_SPARE = 2;
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_DIV    = 8'h04;
    localparam logic [7:0]  OFS_STAT   = 8'h08;
    localparam logic [7:0]  OFS_TXD    = 8'h0C;
    localparam logic [7:0]  OFS_RXD    = 8'h10;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_CTS   = 1;
    localparam int          CTRL_RTS   = 2;
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam int          STAT_BUSY  = 0;
    localparam int          STAT_AVAIL = 1;
    localparam int          STAT_OVR   = 2;
    localparam int          STAT_HOLD  = 3;
    localparam int          STAT_LVL   = 4;

    typedef enum logic [1:0] {HS_DISABLED, HS_RTS, HS_CTS, HS_RTSCTS} fcsp_hs_type;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} fcsp_ser_type;

    function automatic logic [15:0] fcsp_clamp_div(input logic [15:0] d);
        if (d < DIV_MIN) begin
            return DIV_MIN;
        end
        if (d > DIV_MAX) begin
            return DIV_MAX;
        end
        return d;
    endfunction : fcsp_clamp_div
endpackage : fcsp_pkg

// File: rtl/fcsp_target.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_rx (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] div_i,
    input  wire logic        rxd_i,
    output logic [7:0]       data_o,
    output logic             valid_o
);
    fcsp_pkg::fcsp_ser_type st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic        vld_r, vld_nxt;
    logic        tick, half;

    assign tick    = (cnt_r == div_i - 16'h0001);
    assign half    = (cnt_r == (div_i >> 1) - 16'h0001);
    assign data_o  = sh_r;
    assign valid_o = vld_r;

    // Sampling at mid-bit keeps a few percent of rate mismatch harmless.
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
        bit_nxt = bit_r;
        sh_nxt  = sh_r;
        vld_nxt = 1'b0;
        unique case (st_r)
            fcsp_pkg::ST_IDLE: begin
                cnt_nxt = 16'h0000;
                if (!rxd_i) begin
                    st_nxt = fcsp_pkg::ST_START;
                end
            end
            fcsp_pkg::ST_START: if (half) begin
                cnt_nxt = 16'h0000;
                bit_nxt = 3'h0;
                st_nxt  = rxd_i ? fcsp_pkg::ST_IDLE : fcsp_pkg::ST_DATA;
            end
            fcsp_pkg::ST_DATA: if (tick) begin
                sh_nxt  = {rxd_i, sh_r[7:1]};
                bit_nxt = bit_r + 3'h1;
                if (bit_r == 3'h7) begin
                    st_nxt = fcsp_pkg::ST_STOP;
                end
            end
            fcsp_pkg::ST_STOP: if (tick) begin
                st_nxt  = fcsp_pkg::ST_IDLE;
                vld_nxt = rxd_i;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r  <= fcsp_pkg::ST_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 3'h0;
            sh_r  <= 8'h00;
            vld_r <= 1'b0;
        end else if (ce_i) begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sh_r  <= sh_nxt;
            vld_r <= vld_nxt;
        end
    end
endmodule : fcsp_rx

module fcsp_target (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [31:0]      rdata_o,
    fcsp_if.target           lnk
);
    localparam int LW = $clog2(fcsp_pkg::FIFO_D) + 1;
    logic [2:0]    ctrl_r, ctrl_nxt;
    logic [15:0]   div_r, div_nxt;
    logic [7:0]    hold_r, hold_nxt;
    logic          hold_v_r, hold_v_nxt, ovr_r, ovr_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic [1:0]    s1_r, s2_r;
    logic          busy, start, rx_vld, in_rdy, f_vld, pop;
    logic [7:0]    rx_data, f_data;
    logic [LW-1:0] lvl;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    assign start = hold_v_r && !busy && ctrl_r[fcsp_pkg::CTRL_EN]
                   && (!ctrl_r[fcsp_pkg::CTRL_CTS] || s2_r[1]);
    assign pop   = re_i && hit(addr_i, fcsp_pkg::OFS_RXD);
    assign rdata_o         = rdata_r;
    assign lnk.link_en     = ctrl_r[fcsp_pkg::CTRL_EN];
    // Two spare slots cover the character in flight plus the crossing delay.
    assign lnk.recv_permit = !ctrl_r[fcsp_pkg::CTRL_RTS]
        || (lvl < LW'(fcsp_pkg::FIFO_D - fcsp_pkg::FIFO_SPARE));

    always_comb begin
        ctrl_nxt   = ctrl_r;
        div_nxt    = div_r;
        hold_nxt   = hold_r;
        hold_v_nxt = hold_v_r && !start;
        ovr_nxt    = ovr_r;
        rdata_nxt  = 32'h0000_0000;
        if (we_i && hit(addr_i, fcsp_pkg::OFS_CTRL)) begin
            ctrl_nxt = wdata_i[2:0];
        end
        if (we_i && hit(addr_i, fcsp_pkg::OFS_DIV)) begin
            div_nxt = fcsp_pkg::fcsp_clamp_div(wdata_i[15:0]);
        end
        if (we_i && hit(addr_i, fcsp_pkg::OFS_TXD) && !hold_v_r) begin
            hold_nxt   = wdata_i[7:0];
            hold_v_nxt = 1'b1;
        end
        if (we_i && hit(addr_i, fcsp_pkg::OFS_STAT) && wdata_i[fcsp_pkg::STAT_OVR]) begin
            ovr_nxt = 1'b0;
        end
        if (rx_vld && !in_rdy) begin
            ovr_nxt = 1'b1;
        end
        if (re_i) begin
            unique case (addr_i)
                fcsp_pkg::OFS_CTRL: rdata_nxt[2:0] = ctrl_r;
                fcsp_pkg::OFS_DIV:  rdata_nxt[15:0] = div_r;
                fcsp_pkg::OFS_STAT: begin
                    rdata_nxt[fcsp_pkg::STAT_BUSY]  = busy;
                    rdata_nxt[fcsp_pkg::STAT_AVAIL] = f_vld;
                    rdata_nxt[fcsp_pkg::STAT_OVR]   = ovr_r;
                    rdata_nxt[fcsp_pkg::STAT_HOLD]  = hold_v_r;
                    rdata_nxt[fcsp_pkg::STAT_LVL +: LW] = lvl;
                end
                fcsp_pkg::OFS_RXD:  rdata_nxt[7:0] = f_vld ? f_data : 8'h00;
                default:            rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_r   <= fcsp_pkg::CTRL_RST;
            div_r    <= fcsp_pkg::DIV_DEF;
            hold_r   <= 8'h00;
            hold_v_r <= 1'b0;
            ovr_r    <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            s1_r     <= 2'h3;
            s2_r     <= 2'h3;
        end else if (ce_i) begin
            ctrl_r   <= ctrl_nxt;
            div_r    <= div_nxt;
            hold_r   <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            ovr_r    <= ovr_nxt;
            rdata_r  <= rdata_nxt;
            s1_r     <= {lnk.send_permit, lnk.rxd};
            s2_r     <= s1_r;
        end
    end

    fcsp_tx u_tx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .div_i  (div_r),
        .start_i(start),
        .data_i (hold_r),
        .busy_o (busy),
        .txd_o  (lnk.txd)
    );

    fcsp_rx u_rx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .div_i  (div_r),
        .rxd_i  (ctrl_r[fcsp_pkg::CTRL_EN] ? s2_r[0] : 1'b1),
        .data_o (rx_data),
        .valid_o(rx_vld)
    );

    fcsp_fifo #(.W(fcsp_pkg::DATA_W), .D(fcsp_pkg::FIFO_D)) u_fifo (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .in_data_i  (rx_data),
        .in_valid_i (rx_vld),
        .in_ready_o (in_rdy),
        .out_data_o (f_data),
        .out_valid_o(f_vld),
        .out_ready_i(pop),
        .level_o    (lvl)
    );
endmodule : fcsp_target
`default_nettype wire

// File: verif/fcsp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_properties #(
    parameter int BIT_CLKS = 43
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  txd,
    input  wire logic                  rxd,
    input  wire logic                  send_permit_drv,
    input  wire logic                  send_permit_oe,
    input  wire logic                  recv_permit,
    input  wire logic                  link_en,
    input  wire fcsp_pkg::fcsp_hs_type mode_i
);
    localparam int SEND = BIT_CLKS - 1;
    localparam int STOP = 9 * BIT_CLKS;
    localparam int LAST = 10 * BIT_CLKS - 1;
    logic [15:0] tx_pos_r;
    logic [15:0] rx_pos_r;
    logic [3:0]  rp_low_r;
    logic        honour;
    assign honour = mode_i == fcsp_pkg::HS_CTS || mode_i == fcsp_pkg::HS_RTSCTS;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Counters restart on reset, so a reset in mid-frame cannot leave a stale position.
    always_ff @(posedge clk_i) begin
        if (srst_i || tx_pos_r == 16'(LAST)) begin
            tx_pos_r <= '0;
        end else if (tx_pos_r != '0 || !txd) begin
            tx_pos_r <= tx_pos_r + 16'h0001;
        end
        if (srst_i || rx_pos_r == 16'(LAST)) begin
            rx_pos_r <= '0;
        end else if (rx_pos_r != '0 || !rxd) begin
            rx_pos_r <= rx_pos_r + 16'h0001;
        end
        if (srst_i || recv_permit) begin
            rp_low_r <= '0;
        end else if (rp_low_r != 4'hF) begin
            rp_low_r <= rp_low_r + 4'h1;
        end
    end
    a_reset_idle_lines: assert property ($fell(srst_i) |-> txd && rxd && !link_en)
        else $error("lines not idle after reset");
    a_tx_start_low: assert property (tx_pos_r >= 1 && tx_pos_r <= SEND |-> !txd)
        else $error("target start bit wrong width");
    a_tx_stop_high: assert property (tx_pos_r >= STOP |-> txd)
        else $error("target stop bit missing");
    a_rx_start_low: assert property (rx_pos_r >= 1 && rx_pos_r <= SEND |-> !rxd)
        else $error("controller start bit wrong width");
    a_rx_stop_high: assert property (rx_pos_r >= STOP |-> rxd)
        else $error("controller stop bit missing");
    a_permit_drive_mode: assert property (send_permit_oe == (mode_i == fcsp_pkg::HS_RTS ||
        mode_i == fcsp_pkg::HS_RTSCTS))
        else $error("send permit drive does not follow mode");
    // The controller sees the permit through two flops, so a few cycles of lag are allowed.
    a_ctrl_honours_permit: assert property ($fell(rxd) && rx_pos_r == 0 && honour
        |-> rp_low_r < 6)
        else $error("controller started a character while held off");
    a_ctrl_quiet_nolink: assert property ((!link_en) [*5] ##0 rx_pos_r == 0 |-> rxd)
        else $error("controller sent with link disabled");
    a_tgt_quiet_nolink: assert property (!link_en && tx_pos_r == 0 |-> txd)
        else $error("target sent with link disabled");
    c_tx_frame: cover property (tx_pos_r == 16'(LAST));
    c_rx_frame: cover property (rx_pos_r == 16'(LAST));
    c_send_held: cover property (send_permit_oe && !send_permit_drv);
    c_recv_held: cover property (!recv_permit);
endmodule : fcsp_properties
`default_nettype wire

// File: verif/fcsp_test.sv
`timescale 1ns/1ps
`default_nettype none
module fcsp_test;
    localparam logic [15:0] DIV = fcsp_pkg::DIV_MIN;
    localparam int N = 17;
    localparam int STALL = 6600;
    localparam logic [7:0] RA [5] = '{fcsp_pkg::OFS_CTRL, fcsp_pkg::OFS_DIV,
        fcsp_pkg::OFS_STAT, fcsp_pkg::OFS_RXD, 8'h20};
    localparam logic [31:0] RV [5] = '{32'h0, 32'(fcsp_pkg::DIV_DEF), 32'h0, 32'h0, 32'h0};
    logic                  clk_i, srst_i, we_i, re_i, tx_valid_i, rx_ready_i, drain_ok;
    logic                  tx_ready_o, rx_valid_o;
    logic [7:0]            addr_i, tx_data_i, rx_data_o;
    logic [31:0]           wdata_i, rdata_o, rng;
    fcsp_pkg::fcsp_hs_type mode_i;
    int                    error_cnt, n_compared;
    logic [7:0]            t2c_q[$], c2t_q[$];
    fcsp_if lnk();
    fcsp_target i_fcsp_target(.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'h1), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .lnk(lnk));
    fcsp_ctrl i_fcsp_ctrl(.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'h1), .mode_i(mode_i),
        .div_i(DIV), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .lnk(lnk));
    fcsp_properties #(.BIT_CLKS(int'(DIV))) i_fcsp_properties(.clk_i(clk_i), .srst_i(srst_i),
        .txd(lnk.txd), .rxd(lnk.rxd), .send_permit_drv(lnk.send_permit_drv),
        .send_permit_oe(lnk.send_permit_oe), .recv_permit(lnk.recv_permit),
        .link_en(lnk.link_en), .mode_i(mode_i));
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    function logic [7:0] rnd8();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd8
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'h1;
        @(posedge clk_i);
        we_i <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'h1;
        @(posedge clk_i);
        re_i <= 1'h0;
        @(posedge clk_i);
        d = rdata_o;
    endtask : rd
    task send_ctrl(input int n);
        logic [7:0] b;
        int         k;
        for (int i = 0; i < n; i++) begin
            b = rnd8();
            tx_data_i  <= b;
            tx_valid_i <= 1'h1;
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (tx_ready_o !== 1'h1 && k < 30000);
            c2t_q.push_back(b);
        end
        tx_valid_i <= 1'h0;
    endtask : send_ctrl
    // Both directions run at once; each side is stalled only where the mode honours its permit,
    // since a stall without flow control would simply overflow the receiving buffer.
    task burst(input int m);
        logic [31:0] s;
        logic [7:0]  b;
        int          tl, rl, k;
        logic        rts, cts;
        rts = (m == 1 || m == 3);
        cts = (m >= 2);
        mode_i <= fcsp_pkg::fcsp_hs_type'(m[1:0]);
        drain_ok = !cts;
        tl = N;
        rl = N;
        fork
            send_ctrl(N);
            begin
                rx_ready_i <= !rts;
                repeat (STALL) @(posedge clk_i);
                if (rts) chk("send permit", 32'h0, lnk.send_permit);
                if (cts) chk("recv permit", 32'h0, lnk.recv_permit);
                rx_ready_i <= 1'h1;
                drain_ok = 1'h1;
            end
            for (k = 0; k < 40000 && (tl > 0 || rl > 0); k++) begin
                rd(fcsp_pkg::OFS_STAT, s);
                if (!s[fcsp_pkg::STAT_HOLD] && tl > 0) begin
                    b = rnd8();
                    wr(fcsp_pkg::OFS_TXD, {24'h0, b});
                    t2c_q.push_back(b);
                    tl--;
                end
                if (s[fcsp_pkg::STAT_AVAIL] && drain_ok && c2t_q.size() > 0) begin
                    rd(fcsp_pkg::OFS_RXD, s);
                    chk("target rx byte", c2t_q.pop_front(), s);
                    rl--;
                end
            end
        join
        for (k = 0; k < 3000 && t2c_q.size() > 0; k++) @(posedge clk_i);
        chk("bytes left", 32'h0, t2c_q.size());
        rd(fcsp_pkg::OFS_STAT, s);
        chk("overrun", 32'h0, s[fcsp_pkg::STAT_OVR]);
    endtask : burst
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'h1 && rx_ready_i) begin
            if (t2c_q.size() == 0) chk("ctrl rx spare", 32'h0, 32'h1);
            else chk("ctrl rx byte", t2c_q.pop_front(), rx_data_o);
        end
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        give_verdict;
    end
    initial begin
        logic [31:0] s;
        rng = 32'hDD1E;
        {srst_i, we_i, re_i, addr_i, wdata_i, tx_valid_i, tx_data_i} = '0;
        srst_i = 1'h1;
        rx_ready_i = 1'h1;
        drain_ok = 1'h0;
        mode_i = fcsp_pkg::HS_DISABLED;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'h0;
        for (int i = 0; i < 5; i++) begin
            rd(RA[i], s);
            chk("reset value", RV[i], s);
        end
        wr(fcsp_pkg::OFS_DIV, 32'h5);
        rd(fcsp_pkg::OFS_DIV, s);
        chk("div low", 32'(fcsp_pkg::DIV_MIN), s);
        wr(fcsp_pkg::OFS_DIV, 32'hFFFF);
        rd(fcsp_pkg::OFS_DIV, s);
        chk("div high", 32'(fcsp_pkg::DIV_MAX), s);
        wr(fcsp_pkg::OFS_DIV, {16'h0, DIV});
        wr(fcsp_pkg::OFS_CTRL, 32'h7);
        for (int m = 0; m < 4; m++) burst(m);
        wr(fcsp_pkg::OFS_CTRL, 32'h0);
        tx_data_i  <= 8'h3C;
        tx_valid_i <= 1'h1;
        repeat (600) @(posedge clk_i);
        chk("ctrl ready", 32'h0, tx_ready_o);
        wr(fcsp_pkg::OFS_TXD, 32'hA5);
        repeat (600) @(posedge clk_i);
        rd(fcsp_pkg::OFS_STAT, s);
        chk("rx avail", 32'h0, s[fcsp_pkg::STAT_AVAIL]);
        tx_valid_i <= 1'h0;
        give_verdict;
    end
endmodule : fcsp_test
`default_nettype wire
